// *** rtl/thermal_pkg.sv ***
// Purpose: Shared constants for the thermal alert and shutdown logic
// Assumes: 40 MHz core clock, temperatures in 11-bit 0.125 degree steps
// Notes: Limits and hysteresis are whole degrees
package thermal_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int MEAS_TIME_MS = 21;
  localparam int MEAS_CYC = (MEAS_TIME_MS * CLK_HZ) / 1000;
  localparam logic [2:0] RATE_RESET = 3'h2;
  localparam logic [2:0] RATE_MAX = 3'h6;
  localparam logic [7:0] HW_BASE = 8'h4D;
  localparam logic [7:0] HW_STEP_SHDN = 8'h06;
  localparam logic [7:0] HW_STEP_ALERT = 8'h01;
  localparam logic [7:0] HW_REL_HYST = 8'h0A;
  localparam logic [2:0] PULL_MAX = 3'h5;
  localparam logic [2:0] CNT_TOP = 3'h7;
  localparam int CHANS = 2;
  localparam int CH_INT = 0;
  localparam int CH_EXT = 1;

  // Averaging length in half measurement units
  function automatic logic [5:0] avg_halves(input logic [2:0] r,
                                            input logic en);
    logic [5:0] h;
    h = 6'h02;
    if (r >= RATE_MAX) begin
      h = 6'h01;
    end else if (en) begin
      unique case (r)
        3'h0, 3'h1: h = 6'h20;
        3'h2: h = 6'h10;
        3'h3: h = 6'h08;
        3'h4: h = 6'h04;
        default: h = 6'h02;
      endcase
    end
    return h;
  endfunction
endpackage

// *** rtl/chan_if.sv ***
// Purpose: Per-channel link between the top and a limit checker
// Assumes: One instance per measurement channel
// Notes: Checker results hold between conversions
`timescale 1ns/10ps
interface chan_if;
  logic done;
  logic [10:0] temp;
  logic fault;
  logic [7:0] high_limit;
  logic [7:0] low_limit;
  logic [7:0] crit_limit;
  logic [7:0] hyst;
  logic [7:0] hw_limit;
  logic hw_en;
  logic crit_en;
  logic [2:0] alert_consec;
  logic [2:0] shdn_consec;
  logic high_trip;
  logic low_trip;
  logic fault_trip;
  logic comp_trip;
  logic high_clear;
  logic crit_trip;
  logic crit_clear;
  logic hw_trip;
  logic hw_clear;
  modport top (output done, temp, fault, high_limit, low_limit, crit_limit,
    hyst, hw_limit, hw_en, crit_en, alert_consec, shdn_consec,
    input high_trip, low_trip, fault_trip, comp_trip, high_clear,
    crit_trip, crit_clear, hw_trip, hw_clear);
  modport chk (input done, temp, fault, high_limit, low_limit, crit_limit,
    hyst, hw_limit, hw_en, crit_en, alert_consec, shdn_consec,
    output high_trip, low_trip, fault_trip, comp_trip, high_clear,
    crit_trip, crit_clear, hw_trip, hw_clear);
endinterface

// *** rtl/conv_pacer.sv ***
// Purpose: Conversion pacing and external averaging window
// Assumes: Rate code 0..6 for 1..64 conversions per second
// Notes: Window ends before the next conversion start only with the package SEC_CYC and MEAS_CYC; a new start reloads it
`timescale 1ns/10ps
module conv_pacer #(
  parameter int SEC_CYCLES = thermal_pkg::SEC_CYC,
  parameter int MEAS_CYCLES = thermal_pkg::MEAS_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] rate,
  input wire logic averaging_en,
  output logic conv_start,
  output logic ext_measure,
  output logic [5:0] avg_halves
);
  typedef enum logic {PACE_IDLE, PACE_MEAS} pace_e;
  pace_e state, next_state;
  logic [31:0] tick_cnt, next_tick_cnt, meas_cnt, next_meas_cnt;
  logic [31:0] period, window;
  logic [5:0] next_halves;
  logic fire;

  always_comb begin
    period = 32'(SEC_CYCLES) >> rate;
    fire = (tick_cnt >= period - 32'h1);
    next_tick_cnt = fire ? 32'h0 : tick_cnt + 32'h1;
    next_halves = thermal_pkg::avg_halves(rate, averaging_en);
    window = (32'(MEAS_CYCLES) * 32'(next_halves)) >> 1;
    if (window == 32'h0) begin
      window = 32'h1;
    end
    next_state = state;
    next_meas_cnt = meas_cnt;
    if (fire) begin
      next_state = PACE_MEAS;
      next_meas_cnt = window - 32'h1;
    end else if (state == PACE_MEAS) begin
      if (meas_cnt == 32'h0) begin
        next_state = PACE_IDLE;
      end else begin
        next_meas_cnt = meas_cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= PACE_IDLE;
      tick_cnt <= 32'h0;
      meas_cnt <= 32'h0;
      conv_start <= 1'b0;
      ext_measure <= 1'b0;
      avg_halves <= 6'h10;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      meas_cnt <= next_meas_cnt;
      conv_start <= fire;
      ext_measure <= (next_state == PACE_MEAS);
      avg_halves <= next_halves;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_TOP_RATE_HALF: assert property (
    rate >= thermal_pkg::RATE_MAX |=> avg_halves == 6'h01)
    else $error("averaging not halved at top rate");
  AST_START_OPENS_WINDOW: assert property (
    conv_start |-> ext_measure)
    else $error("measure window not open at start");
endmodule

// *** rtl/chan_check.sv ***
// Purpose: Limit checks and consecutive counters for one channel
// Assumes: done pulses once per completed conversion
// Notes: Results update only on done
`timescale 1ns/10ps
module chan_check (
  input wire logic core_clk,
  input wire logic resetn,
  chan_if.chk ch
);
  logic [2:0] alert_cnt, next_alert_cnt, shdn_cnt, next_shdn_cnt;
  logic [7:0] deg;
  logic [8:0] deg_h, deg_r;
  logic hi_now, lo_now, gt_now, crit_now, hw_now, alert_out, shdn_out;

  always_comb begin
    deg = ch.fault ? 8'h00 : ch.temp[10:3];
    deg_h = {1'b0, deg} + {1'b0, ch.hyst};
    deg_r = {1'b0, deg} + {1'b0, thermal_pkg::HW_REL_HYST};
    hi_now = deg >= ch.high_limit;
    gt_now = deg > ch.high_limit;
    lo_now = !ch.fault && (deg < ch.low_limit);
    crit_now = ch.crit_en && (deg > ch.crit_limit);
    hw_now = ch.hw_en && (deg > ch.hw_limit);
    alert_out = hi_now || lo_now || ch.fault;
    shdn_out = hw_now || crit_now;
    next_alert_cnt = alert_cnt;
    next_shdn_cnt = shdn_cnt;
    if (ch.done) begin
      next_alert_cnt = !alert_out ? 3'h0 : (alert_cnt == thermal_pkg::CNT_TOP
        ? alert_cnt : alert_cnt + 3'h1);
      next_shdn_cnt = !shdn_out ? 3'h0 : (shdn_cnt == thermal_pkg::CNT_TOP
        ? shdn_cnt : shdn_cnt + 3'h1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      alert_cnt <= 3'h0;
      shdn_cnt <= 3'h0;
      ch.high_trip <= 1'b0;
      ch.low_trip <= 1'b0;
      ch.fault_trip <= 1'b0;
      ch.comp_trip <= 1'b0;
      ch.high_clear <= 1'b1;
      ch.crit_trip <= 1'b0;
      ch.crit_clear <= 1'b1;
      ch.hw_trip <= 1'b0;
      ch.hw_clear <= 1'b1;
    end else begin
      alert_cnt <= next_alert_cnt;
      shdn_cnt <= next_shdn_cnt;
      if (ch.done) begin
        ch.high_trip <= hi_now && (alert_cnt >= ch.alert_consec);
        ch.low_trip <= lo_now && (alert_cnt >= ch.alert_consec);
        ch.fault_trip <= ch.fault && (alert_cnt >= ch.alert_consec);
        ch.comp_trip <= gt_now && (alert_cnt >= ch.alert_consec);
        ch.high_clear <= deg_h < {1'b0, ch.high_limit};
        ch.crit_trip <= crit_now && (shdn_cnt >= ch.shdn_consec);
        ch.crit_clear <= !ch.crit_en || (deg_h < {1'b0, ch.crit_limit});
        ch.hw_trip <= hw_now && (shdn_cnt >= ch.shdn_consec);
        ch.hw_clear <= !ch.hw_en || (deg_r < {1'b0, ch.hw_limit});
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_FAULT_NO_LOW: assert property (
    ch.done && ch.fault |=> !ch.low_trip)
    else $error("low limit checked on faulted channel");
  AST_CONSEC_GATES: assert property (
    ch.done && alert_cnt < ch.alert_consec |=> !ch.high_trip)
    else $error("alert trip before consecutive count");
endmodule

// *** rtl/thermal_alert_shutdown_logic.sv ***
// Purpose: Alert and shutdown decision logic of a two-channel monitor
// Assumes: Front end delivers results with done pulses; straps valid
// Notes: Pins are open drain; data outputs are held low
`timescale 1ns/10ps
module thermal_alert_shutdown_logic #(
  parameter int SEC_CYCLES = thermal_pkg::SEC_CYC,
  parameter int MEAS_CYCLES = thermal_pkg::MEAS_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic rate_wr,
  input wire logic [2:0] rate_data,
  input wire logic averaging_en,
  input wire logic alert_comp_mode,
  input wire logic mask_set,
  input wire logic mask_clr,
  input wire logic alert_response_query,
  input wire logic [1:0] chan_mask,
  input wire logic [1:0] shdn_link,
  input wire logic status_clr,
  input wire logic int_done,
  input wire logic [10:0] int_temp,
  input wire logic ext_done,
  input wire logic [10:0] ext_temp,
  input wire logic ext_fault,
  input wire logic [7:0] high_limit_int,
  input wire logic [7:0] high_limit_ext,
  input wire logic [7:0] low_limit_int,
  input wire logic [7:0] low_limit_ext,
  input wire logic [7:0] critical_limit_int,
  input wire logic [7:0] critical_limit_ext,
  input wire logic [7:0] critical_hysteresis,
  input wire logic [2:0] alert_consec,
  input wire logic [2:0] shdn_consec,
  input wire logic [2:0] shdn_pull_code,
  input wire logic [2:0] alert_pull_code,
  output logic conv_start,
  output logic ext_measure,
  output logic [5:0] avg_halves,
  output logic [2:0] rate,
  output logic global_mask,
  output logic [1:0] high_status,
  output logic [1:0] low_status,
  output logic [1:0] fault_status,
  output logic [10:0] ext_result,
  output logic [7:0] hw_limit,
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic shutdown_n_output_out,
  output logic shutdown_n_output_oe
);
  logic [2:0] next_rate;
  logic next_global_mask;
  logic [1:0] next_high_status, next_low_status, next_fault_status;
  logic [1:0] high_trip, low_trip, fault_trip, comp_trip;
  logic [1:0] high_clear, crit_trip, crit_clear;
  logic [1:0] unmasked;
  logic comp_active, next_comp_active;
  logic next_alert, next_shdn, alert_int, all_high_clear;
  logic strap_done;
  logic [7:0] next_hw_limit;
  logic [2:0] shdn_sel, alert_sel;
  logic [10:0] next_ext_result;

  chan_if chb [1:0] ();

  conv_pacer #(
    .SEC_CYCLES(SEC_CYCLES),
    .MEAS_CYCLES(MEAS_CYCLES)
  ) u_pacer (
    .core_clk(core_clk),
    .resetn(resetn),
    .rate(rate),
    .averaging_en(averaging_en),
    .conv_start(conv_start),
    .ext_measure(ext_measure),
    .avg_halves(avg_halves)
  );

  genvar g;
  generate
    for (g = 0; g < thermal_pkg::CHANS; g++) begin : g_chan
      localparam bit IS_EXT = (g == thermal_pkg::CH_EXT);
      assign chb[g].done = IS_EXT ? ext_done : int_done;
      assign chb[g].temp = IS_EXT ? ext_temp : int_temp;
      assign chb[g].fault = IS_EXT ? ext_fault : 1'b0;
      assign chb[g].high_limit = IS_EXT ? high_limit_ext : high_limit_int;
      assign chb[g].low_limit = IS_EXT ? low_limit_ext : low_limit_int;
      assign chb[g].crit_limit = IS_EXT ? critical_limit_ext
                                        : critical_limit_int;
      assign chb[g].hyst = critical_hysteresis;
      assign chb[g].hw_limit = hw_limit;
      assign chb[g].hw_en = IS_EXT && strap_done;
      assign chb[g].crit_en = shdn_link[g];
      assign chb[g].alert_consec = alert_consec;
      assign chb[g].shdn_consec = shdn_consec;
      assign high_trip[g] = chb[g].high_trip;
      assign low_trip[g] = chb[g].low_trip;
      assign fault_trip[g] = chb[g].fault_trip;
      assign comp_trip[g] = chb[g].comp_trip;
      assign high_clear[g] = chb[g].high_clear;
      assign crit_trip[g] = chb[g].crit_trip;
      assign crit_clear[g] = chb[g].crit_clear;
      chan_check u_check (
        .core_clk(core_clk),
        .resetn(resetn),
        .ch(chb[g])
      );
    end
  endgenerate

  // Configuration and hardware limit
  always_comb begin
    next_rate = rate;
    if (rate_wr) begin
      next_rate = (rate_data > thermal_pkg::RATE_MAX)
        ? thermal_pkg::RATE_MAX : rate_data;
    end
    shdn_sel = (shdn_pull_code > thermal_pkg::PULL_MAX)
      ? thermal_pkg::PULL_MAX : shdn_pull_code;
    alert_sel = (alert_pull_code > thermal_pkg::PULL_MAX)
      ? thermal_pkg::PULL_MAX : alert_pull_code;
    next_hw_limit = hw_limit;
    if (!strap_done) begin
      next_hw_limit = thermal_pkg::HW_BASE
        + 8'(shdn_sel * thermal_pkg::HW_STEP_SHDN)
        + 8'(alert_sel * thermal_pkg::HW_STEP_ALERT);
    end
    next_ext_result = ext_result;
    if (ext_done) begin
      next_ext_result = ext_fault ? 11'h000 : ext_temp;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rate <= thermal_pkg::RATE_RESET;
      strap_done <= 1'b0;
      hw_limit <= thermal_pkg::HW_BASE;
      ext_result <= 11'h000;
    end else begin
      rate <= next_rate;
      strap_done <= 1'b1;
      hw_limit <= next_hw_limit;
      ext_result <= next_ext_result;
    end
  end

  // Alert status, mask and pin
  always_comb begin
    unmasked = ~chan_mask;
    all_high_clear = &high_clear;
    next_global_mask = global_mask;
    if (mask_clr) begin
      next_global_mask = 1'b0;
    end
    if (mask_set || alert_response_query) begin
      next_global_mask = 1'b1;
    end
    next_comp_active = comp_active;
    if (comp_active) begin
      next_comp_active = !all_high_clear;
    end else begin
      next_comp_active = |(unmasked & comp_trip);
    end
    next_low_status = low_status;
    next_fault_status = fault_status;
    next_high_status = high_status;
    if (status_clr) begin
      next_low_status = 2'h0;
      next_fault_status = 2'h0;
      if (!alert_comp_mode) begin
        next_high_status = 2'h0;
      end
    end
    if (alert_comp_mode) begin
      if (!comp_active) begin
        next_high_status = 2'h0;
      end
      next_high_status = next_high_status | (comp_trip & {2{
        next_comp_active}});
    end else begin
      next_high_status = next_high_status | high_trip;
    end
    next_low_status = next_low_status | low_trip;
    next_fault_status = next_fault_status | fault_trip;
    alert_int = |(unmasked & (high_status | low_status | fault_status
      | high_trip | low_trip | fault_trip));
    if (alert_comp_mode) begin
      next_alert = comp_active;
    end else begin
      next_alert = alert_int && !global_mask;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      global_mask <= 1'b0;
      comp_active <= 1'b0;
      high_status <= 2'h0;
      low_status <= 2'h0;
      fault_status <= 2'h0;
      alert_n_out <= 1'b0;
      alert_n_oe <= 1'b0;
    end else begin
      global_mask <= next_global_mask;
      comp_active <= next_comp_active;
      high_status <= next_high_status;
      low_status <= next_low_status;
      fault_status <= next_fault_status;
      alert_n_out <= 1'b0;
      alert_n_oe <= next_alert;
    end
  end

  // Shutdown pin, no mask input anywhere in this path
  always_comb begin
    if (shutdown_n_output_oe) begin
      next_shdn = !(chb[thermal_pkg::CH_EXT].hw_clear
        && &crit_clear);
    end else begin
      next_shdn = chb[thermal_pkg::CH_EXT].hw_trip
        || |(shdn_link & crit_trip);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_n_output_out <= 1'b0;
      shutdown_n_output_oe <= 1'b0;
    end else begin
      shutdown_n_output_out <= 1'b0;
      shutdown_n_output_oe <= next_shdn;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence seq_int_cause;
    !alert_comp_mode && !global_mask
      && |(~chan_mask & (low_trip | fault_trip | high_trip));
  endsequence
  sequence seq_mask_hold;
    !alert_comp_mode && global_mask && !mask_clr;
  endsequence

  AST_RATE_HOLDS: assert property (
    !rate_wr |=> $stable(rate))
    else $error("rate changed without write");
  AST_RATE_WRITE: assert property (
    rate_wr && rate_data <= 3'h6 |=> rate == $past(rate_data))
    else $error("rate write not taken");
  AST_INT_ALERT: assert property (
    seq_int_cause |=> alert_n_oe)
    else $error("interrupt alert missed");
  AST_MASK_RELEASE: assert property (
    seq_mask_hold ##1 !alert_comp_mode |-> !alert_n_oe)
    else $error("masked alert still driven");
  AST_ARA_MASK: assert property (
    alert_response_query |=> global_mask)
    else $error("query did not set mask");
  AST_OPEN_DRAIN: assert property (
    !alert_n_out && !shutdown_n_output_out)
    else $error("open drain pin driven high");
  AST_COMP_STATUS: assert property (
    alert_comp_mode && comp_active && status_clr
      |=> (high_status & $past(high_status)) == $past(high_status))
    else $error("comparator status cleared while alert on");
  AST_SHDN_TRIP: assert property (
    chb[1].hw_trip && !shutdown_n_output_oe ##0 global_mask
      |=> shutdown_n_output_oe)
    else $error("shutdown masked or missed");
  AST_SHDN_HOLD: assert property (
    shutdown_n_output_oe && !chb[1].hw_clear |=> shutdown_n_output_oe)
    else $error("shutdown released above release point");
  AST_HW_LIMIT_FIXED: assert property (
    strap_done |=> $stable(hw_limit))
    else $error("hardware limit changed");
endmodule

// *** test/host_model.sv ***
// Purpose: Host side that watches the shared alert line
// Assumes: Line is pulled up whenever nobody drives it
// Notes: Answers each alert with one query pulse when enabled
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic alert_n,
  input wire logic auto_ack,
  output logic alert_response_query
);
  logic [2:0] dly;
  logic seen;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dly <= 3'h0;
      seen <= 1'b0;
      alert_response_query <= 1'b0;
    end else begin
      alert_response_query <= dly == 3'h1;
      if (dly == 3'h1) seen <= 1'b1;
      else if (alert_n) seen <= 1'b0;
      if (dly != 3'h0) dly <= dly - 3'h1;
      else if (auto_ack && !alert_n && !seen) dly <= 3'h4;
    end
  end
endmodule

// *** test/thermal_alert_shutdown_logic_tb.sv ***
// Purpose: Self-checking bench with a behavioural reference
// Assumes: Short pacing counts of 64 and 4 cycles
// Notes: Checks are made five cycles after each event
`timescale 1ns/10ps
module thermal_alert_shutdown_logic_tb;
  logic core_clk = 0, resetn = 0, rate_wr = 0, averaging_en = 1;
  logic alert_comp_mode = 0, mask_set = 0, mask_clr = 0, status_clr = 0;
  logic int_done = 0, ext_done = 0, ext_fault = 0, auto_ack = 0;
  logic alert_response_query, alert_n, conv_start, ext_measure;
  logic global_mask, alert_n_out, alert_n_oe;
  logic shutdown_n_output_out, shutdown_n_output_oe;
  logic [1:0] chan_mask = 0, shdn_link = 0;
  logic [1:0] high_status, low_status, fault_status;
  logic [2:0] rate_data = 0, alert_consec = 0, shdn_consec = 1, rate;
  logic [2:0] shdn_pull_code = 3'h3, alert_pull_code = 3'h2;
  logic [5:0] avg_halves;
  logic [7:0] high_limit_int = 8'h46, high_limit_ext = 8'h46;
  logic [7:0] low_limit_int = 8'h0A, low_limit_ext = 8'h0A;
  logic [7:0] critical_limit_int = 8'h50, critical_limit_ext = 8'h78;
  logic [7:0] critical_hysteresis = 8'h05, hw_limit;
  logic [10:0] int_temp = 0, ext_temp = 0, ext_result;
  logic [15:0] lf = 16'h521A;
  int fails = 0, n_tests = 0, hs, ls, fs, mask, ca, sd, n, rr, ht, lw, ft;
  int lt[2], sc[2], ac[2];
  localparam int HW = 97;
  always #12.5 core_clk = ~core_clk;
  assign alert_n = alert_n_oe ? alert_n_out : 1'b1;
  thermal_alert_shutdown_logic #(.SEC_CYCLES(64), .MEAS_CYCLES(4)) uut (
    .core_clk, .resetn, .rate_wr, .rate_data, .averaging_en,
    .alert_comp_mode, .mask_set, .mask_clr, .alert_response_query,
    .chan_mask, .shdn_link, .status_clr, .int_done, .int_temp, .ext_done,
    .ext_temp, .ext_fault, .high_limit_int, .high_limit_ext,
    .low_limit_int, .low_limit_ext, .critical_limit_int,
    .critical_limit_ext, .critical_hysteresis, .alert_consec,
    .shdn_consec, .shdn_pull_code, .alert_pull_code, .conv_start,
    .ext_measure, .avg_halves, .rate, .global_mask, .high_status,
    .low_status, .fault_status, .ext_result, .hw_limit, .alert_n_out,
    .alert_n_oe, .shutdown_n_output_out, .shutdown_n_output_oe);
  host_model host (.core_clk, .resetn, .alert_n, .auto_ack,
    .alert_response_query);
  task automatic chk(string s, logic [10:0] v, logic [10:0] e);
    n_tests++;
    if (v !== e) begin
      fails++;
      $display("mismatch %s exp %0h got %0h", s, e, v);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic void upd(int c, int t, int f);
    int tt, trip, clr, ov, hy, al;
    int hl[2], ll[2], cl[2];
    hl = '{int'(high_limit_int), int'(high_limit_ext)};
    ll = '{int'(low_limit_int), int'(low_limit_ext)};
    cl = '{int'(critical_limit_int), int'(critical_limit_ext)};
    hy = critical_hysteresis;
    tt = f ? 0 : t;
    lt[c] = tt;
    al = tt >= hl[c] || (!f && tt < ll[c]) || f;
    ac[c] = al ? (ac[c] < 7 ? ac[c] + 1 : 7) : 0;
    al = ac[c] > alert_consec;
    // Latest trips stand until the channel's next result
    ht &= ~(1 << c);
    lw &= ~(1 << c);
    ft &= ~(1 << c);
    if (al && tt >= hl[c]) ht |= 1 << c;
    if (al && !f && tt < ll[c]) lw |= 1 << c;
    if (al && f) ft |= 1 << c;
    ls |= lw;
    fs |= ft;
    if (alert_comp_mode) begin
      trip = 0;
      clr = 1;
      for (int i = 0; i < 2; i++) begin
        if (!chan_mask[i] && lt[i] > hl[i]) trip = 1;
        if (lt[i] >= hl[i] - hy) clr = 0;
      end
      if (trip) ca = 1;
      else if (clr) ca = 0;
      hs = ca ? hs : 0;
      for (int i = 0; i < 2; i++) if (ca && lt[i] > hl[i]) hs |= 1 << i;
    end else begin
      hs |= ht;
    end
    ov = (c == 1 && tt > HW) || (shdn_link[c] && tt > cl[c]);
    sc[c] = ov ? (sc[c] < 7 ? sc[c] + 1 : 7) : 0;
    if (sc[c] > shdn_consec) sd = 1;
    else if (lt[1] < HW - 10 && (!shdn_link[0] || lt[0] < cl[0] - hy)
      && (!shdn_link[1] || lt[1] < cl[1] - hy)) sd = 0;
  endfunction
  task automatic settle();
    int ea;
    repeat (5) @(posedge core_clk);
    #1;
    ea = alert_comp_mode ? ca : !mask && ((hs | ls | fs) & ~chan_mask);
    chk("high", 11'(high_status), 11'(hs));
    chk("low", 11'(low_status), 11'(ls));
    chk("fault", 11'(fault_status), 11'(fs));
    chk("alert", 11'(alert_n), 11'(!ea));
    chk("drive", 11'(alert_n_out), 11'(0));
    chk("shdn", 11'(shutdown_n_output_oe), 11'(sd));
    chk("sdrv", 11'(shutdown_n_output_out), 11'(0));
    chk("result", ext_result, 11'(lt[1] * 8));
    chk("mask", 11'(global_mask), 11'(mask));
    @(posedge core_clk);
  endtask
  task automatic conv(int c, int t, int f = 0);
    if (c) begin
      ext_temp <= 11'(t * 8);
      ext_fault <= f[0];
      ext_done <= 1'b1;
    end else begin
      int_temp <= 11'(t * 8);
      int_done <= 1'b1;
    end
    @(posedge core_clk);
    ext_done <= 1'b0;
    int_done <= 1'b0;
    upd(c, t, f);
    settle();
  endtask
  task automatic pulse(int k);
    mask_set <= k == 0;
    mask_clr <= k == 1;
    status_clr <= k == 2;
    @(posedge core_clk);
    {mask_set, mask_clr, status_clr} <= 3'h0;
    if (k < 2) mask = k == 0;
    if (k == 2) begin
      ls = lw;
      fs = ft;
      hs = alert_comp_mode ? hs : ht;
    end
    settle();
  endtask
  initial begin
    #(25 * 40000);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    settle();
    chk("rate0", 11'(rate), 11'(2));
    chk("hw", 11'(hw_limit), 11'(HW));
    {shdn_pull_code, alert_pull_code} <= 6'h00;
    pulse(0);
    pulse(1);
    chk("hw", 11'(hw_limit), 11'(HW));
    for (int e = 0; e < 2; e++) begin
      for (int r = 0; r < 8; r++) begin
        averaging_en <= e[0];
        rate_data <= 3'(r);
        rate_wr <= 1'b1;
        @(posedge core_clk);
        rate_wr <= 1'b0;
        rr = r > 6 ? 6 : r;
        for (int k = 0; k < 3; k++) begin
          n = 0;
          do begin
            @(posedge core_clk);
            #1;
            n++;
          end while (conv_start !== 1'b1 && n < 200);
        end
        chk("period", 11'(n), 11'(64 >> rr));
        chk("meas", 11'(ext_measure), 11'(1));
        chk("rate", 11'(rate), 11'(rr));
        n = rr > 5 ? 1 : !e ? 2 : rr < 2 ? 32 : 64 >> rr;
        chk("avg", 11'(avg_halves), 11'(n));
        @(posedge core_clk);
      end
    end
    conv(0, 30);
    conv(1, 40);
    conv(1, 70);
    conv(1, 50);
    pulse(2);
    conv(1, 69);
    conv(1, 5);
    pulse(2);
    conv(1, 40, 1);
    pulse(2);
    conv(0, 70);
    pulse(0);
    conv(0, 75);
    pulse(1);
    auto_ack <= 1'b1;
    repeat (12) @(posedge core_clk);
    mask = 1;
    settle();
    auto_ack <= 1'b0;
    pulse(1);
    pulse(2);
    chan_mask <= 2'h2;
    conv(1, 75);
    chan_mask <= 2'h0;
    settle();
    pulse(2);
    conv(1, 98);
    pulse(0);
    conv(1, 98);
    conv(1, 90);
    conv(1, 86);
    pulse(1);
    shdn_link <= 2'h1;
    conv(0, 81);
    conv(0, 81);
    conv(0, 76);
    conv(0, 74);
    shdn_link <= 2'h0;
    pulse(2);
    for (int i = 0; i < 24; i++) begin
      lf = lfsr(lf);
      high_limit_ext <= 8'(60 + lf[3:0]);
      low_limit_ext <= 8'(15 + lf[6:4]);
      conv(lf[7], 15 + lf[15:8] % 60);
      if (lf[8]) pulse(2);
    end
    alert_consec <= 3'h1;
    conv(0, 20);
    conv(0, 72);
    conv(0, 72);
    alert_consec <= 3'h0;
    pulse(2);
    high_limit_ext <= 8'h46;
    conv(1, 30);
    alert_comp_mode <= 1'b1;
    conv(0, 30);
    conv(1, 71);
    pulse(2);
    conv(1, 70);
    conv(1, 65);
    conv(1, 64);
    pulse(0);
    conv(1, 71);
    conv(1, 60);
    pulse(1);
    chan_mask <= 2'h2;
    conv(1, 80);
    chan_mask <= 2'h0;
    conv(1, 60);
    wrap_up();
  end
endmodule
